//--- core/escs_host.sv
`timescale 1ns/100ps
`include "escs_consts.svh"
// Host-side sequencer driving chip erase, suspend and resume on the flash pins.
module escs_host
   import escs_pkg::*;
#(
   parameter int unsigned ERS_SUSP_CYC = `ESCS_ERS_SUSP_CYC,
   parameter int unsigned PGM_SUSP_CYC = `ESCS_PGM_SUSP_CYC,
   parameter int unsigned T_WR         = `ESCS_T_WR_CYC,
   parameter int unsigned T_RD         = `ESCS_T_RD_CYC
) (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        req_valid,
   output      logic        req_ready,
   input  wire escs_req_t   req,
   output      logic        rsp_valid,
   output      escs_rsp_t   rsp,
   input  wire logic [15:0] dq_in,
   output      escs_pins_t  pins,
   output      logic        flash_reset_n
);
   initial begin
      if (ERS_SUSP_CYC < 1 || PGM_SUSP_CYC < 1 || ERS_SUSP_CYC > 65535 ||
          PGM_SUSP_CYC > 65535) begin
         $error("escs_host: suspend wait out of range");
      end
   end

   typedef enum logic [2:0] {
      S_IDLE,
      S_WRITE,
      S_POLL,
      S_CHECK,
      S_RESP
   } escs_state_t;

   typedef struct packed {
      escs_state_t state;
      escs_cmd_t   cmd;
      logic [2:0]  step;
      logic [22:0] addr;
      logic [15:0] wait_cnt;
      logic [15:0] last;
      logic        have_last;
      logic        erasing;
      logic        suspended;
      logic        chip_busy;
      logic        rst_n;
      escs_rsp_t   rsp;
   } escs_host_st_t;

   escs_host_st_t st_ff;
   escs_host_st_t nxt_st;

   logic        bc_go;
   logic        bc_wr;
   logic [22:0] bc_addr;
   logic [15:0] bc_wdata;
   logic        bc_busy;
   logic        bc_done;
   logic [15:0] bc_rdata;
   logic [2:0]  nsteps;
   logic        toggling;

   escs_bus_cycle #(
      .T_WR (T_WR),
      .T_RD (T_RD)
   ) u_cycle (
      .clk      (clk),
      .srst     (srst),
      .go       (bc_go),
      .is_write (bc_wr),
      .addr     (bc_addr),
      .wdata    (bc_wdata),
      .dq_in    (dq_in),
      .busy     (bc_busy),
      .done     (bc_done),
      .rdata    (bc_rdata),
      .pins     (pins)
   );

   // Chip erase table, one write per step
   always_comb begin
      bc_addr  = st_ff.addr;
      bc_wdata = `ESCS_DATA_SUSPEND;
      nsteps   = 3'd1;
      case (st_ff.cmd)
         ESCS_CMD_CHIP_ERASE: begin
            nsteps = 3'd6;
            case (st_ff.step)
               3'd0, 3'd3: begin
                  bc_addr  = `ESCS_ADDR_UNLOCK1;
                  bc_wdata = `ESCS_DATA_UNLOCK1;
               end
               3'd1, 3'd4: begin
                  bc_addr  = `ESCS_ADDR_UNLOCK2;
                  bc_wdata = `ESCS_DATA_UNLOCK2;
               end
               3'd2: begin
                  bc_addr  = `ESCS_ADDR_UNLOCK1;
                  bc_wdata = `ESCS_DATA_SETUP;
               end
               default: begin
                  bc_addr  = `ESCS_ADDR_UNLOCK1;
                  bc_wdata = `ESCS_DATA_CHIP;
               end
            endcase
         end
         ESCS_CMD_ERASE_RESUME, ESCS_CMD_PGM_RESUME: bc_wdata = `ESCS_DATA_RESUME;
         default: bc_wdata = `ESCS_DATA_SUSPEND;
      endcase
   end

   // Toggle bits flip between consecutive reads while the device is busy
   assign toggling = st_ff.have_last &&
                     ((bc_rdata[`ESCS_BIT_TOGGLE_A] != st_ff.last[`ESCS_BIT_TOGGLE_A]) ||
                      (bc_rdata[`ESCS_BIT_TOGGLE_B] != st_ff.last[`ESCS_BIT_TOGGLE_B]));

   assign bc_go     = !bc_busy && !bc_done &&
                      (st_ff.state == S_WRITE || st_ff.state == S_POLL);
   assign bc_wr     = (st_ff.state == S_WRITE);
   assign req_ready = (st_ff.state == S_IDLE) && st_ff.rst_n;

   always_comb begin
      nxt_st         = st_ff;
      nxt_st.rst_n   = 1'b1;
      nxt_st.rsp.done = 1'b0;
      case (st_ff.state)
         S_IDLE: begin
            if (req_valid && st_ff.rst_n) begin
               nxt_st.cmd       = req.cmd;
               nxt_st.addr      = req.addr;
               nxt_st.step      = 3'd0;
               nxt_st.wait_cnt  = 16'h0000;
               nxt_st.have_last = 1'b0;
               nxt_st.rsp       = '0;
               // Writes during chip erase would be dropped; poll instead
               if (st_ff.chip_busy && req.cmd != ESCS_CMD_POLL) begin
                  nxt_st.state    = S_RESP;
               end else if (req.cmd == ESCS_CMD_POLL) begin
                  nxt_st.state = S_POLL;
               end else begin
                  nxt_st.state = S_WRITE;
               end
            end
         end
         S_WRITE: begin
            if (bc_done) begin
               if (st_ff.step == nsteps - 3'd1) begin
                  nxt_st.state = S_POLL;
                  case (st_ff.cmd)
                     ESCS_CMD_CHIP_ERASE: nxt_st.chip_busy = 1'b1;
                     ESCS_CMD_ERASE_SUSPEND, ESCS_CMD_PGM_SUSPEND: nxt_st.suspended = 1'b1;
                     ESCS_CMD_ERASE_RESUME, ESCS_CMD_PGM_RESUME: begin
                        nxt_st.suspended = 1'b0;
                        nxt_st.state     = S_RESP;
                        nxt_st.rsp.ok    = 1'b1;
                     end
                     default: nxt_st.suspended = st_ff.suspended;
                  endcase
               end else begin
                  nxt_st.step = st_ff.step + 3'd1;
               end
            end
         end
         S_POLL: begin
            // Suspend wait counts clock cycles, not reads, so the limit is real time
            nxt_st.wait_cnt = st_ff.wait_cnt + 16'h0001;
            if (bc_done) begin
               nxt_st.state = S_CHECK;
            end
         end
         S_CHECK: begin
            nxt_st.last       = bc_rdata;
            nxt_st.have_last  = 1'b1;
            nxt_st.rsp.status = bc_rdata;
            nxt_st.wait_cnt   = st_ff.wait_cnt + 16'h0001;
            if (st_ff.have_last && !toggling) begin
               // Quiet toggle bits: erase done, or suspended
               nxt_st.state      = S_RESP;
               nxt_st.rsp.ok     = 1'b1;
               if (st_ff.cmd == ESCS_CMD_CHIP_ERASE || st_ff.cmd == ESCS_CMD_POLL) begin
                  nxt_st.rsp.ok    = (st_ff.cmd == ESCS_CMD_POLL) ||
                                     bc_rdata[`ESCS_BIT_POLL];
                  nxt_st.chip_busy = 1'b0;
               end
            end else if (st_ff.cmd == ESCS_CMD_POLL && st_ff.have_last) begin
               nxt_st.state = S_RESP;
            end else if (st_ff.cmd == ESCS_CMD_ERASE_SUSPEND &&
                         st_ff.wait_cnt >= 16'(ERS_SUSP_CYC)) begin
               nxt_st.state       = S_RESP;
               nxt_st.rsp.timeout = 1'b1;
            end else if (st_ff.cmd == ESCS_CMD_PGM_SUSPEND &&
                         st_ff.wait_cnt >= 16'(PGM_SUSP_CYC)) begin
               nxt_st.state       = S_RESP;
               nxt_st.rsp.timeout = 1'b1;
            end else begin
               nxt_st.state = S_POLL;
            end
         end
         S_RESP: begin
            nxt_st.rsp.done = 1'b1;
            nxt_st.state    = S_IDLE;
         end
         default: nxt_st.state = S_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Device reset pulses low while ours is asserted; aborts any erase
   assign flash_reset_n = st_ff.rst_n;
   assign rsp_valid     = st_ff.rsp.done;
   assign rsp           = st_ff.rsp;
endmodule

//--- core/escs_consts.svh
`ifndef ESCS_CONSTS_SVH
`define ESCS_CONSTS_SVH

`define ESCS_ADDR_UNLOCK1   23'h00_0555
`define ESCS_ADDR_UNLOCK2   23'h00_02AA
`define ESCS_DATA_UNLOCK1   16'h00AA
`define ESCS_DATA_UNLOCK2   16'h0055
`define ESCS_DATA_SETUP     16'h0080
`define ESCS_DATA_CHIP      16'h0010
`define ESCS_DATA_SUSPEND   16'h00B0
`define ESCS_DATA_RESUME    16'h0030
`define ESCS_DATA_ERASED    16'hFFFF
`define ESCS_BIT_POLL       7
`define ESCS_BIT_TOGGLE_A   6
`define ESCS_BIT_TOGGLE_B   2
`define ESCS_CLK_MHZ        40
`define ESCS_ERS_SUSP_US    20
`define ESCS_PGM_SUSP_US    15
`define ESCS_ERS_SUSP_CYC   (`ESCS_ERS_SUSP_US * `ESCS_CLK_MHZ)
`define ESCS_PGM_SUSP_CYC   (`ESCS_PGM_SUSP_US * `ESCS_CLK_MHZ)
`define ESCS_T_WR_CYC       4
`define ESCS_T_RD_CYC       4
`endif

//--- core/escs_pkg.sv
package escs_pkg;
   typedef enum logic [2:0] {
      ESCS_CMD_CHIP_ERASE,
      ESCS_CMD_ERASE_SUSPEND,
      ESCS_CMD_ERASE_RESUME,
      ESCS_CMD_PGM_SUSPEND,
      ESCS_CMD_PGM_RESUME,
      ESCS_CMD_POLL
   } escs_cmd_t;

   typedef struct packed {
      escs_cmd_t   cmd;
      logic [22:0] addr;
   } escs_req_t;

   typedef struct packed {
      logic        done;
      logic        ok;
      logic        timeout;
      logic [15:0] status;
   } escs_rsp_t;

   typedef struct packed {
      logic [22:0] addr;
      logic [15:0] dout;
      logic        dout_en;
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
   } escs_pins_t;
endpackage

//--- core/escs_bus_cycle.sv
`timescale 1ns/100ps
`include "escs_consts.svh"
// One asynchronous write or read cycle on the flash pins.
module escs_bus_cycle
   import escs_pkg::*;
#(
   parameter int unsigned T_WR = `ESCS_T_WR_CYC,
   parameter int unsigned T_RD = `ESCS_T_RD_CYC
) (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        go,
   input  wire logic        is_write,
   input  wire logic [22:0] addr,
   input  wire logic [15:0] wdata,
   input  wire logic [15:0] dq_in,
   output      logic        busy,
   output      logic        done,
   output      logic [15:0] rdata,
   output      escs_pins_t  pins
);
   initial begin
      if (T_WR < 2 || T_RD < 3 || T_WR > 255 || T_RD > 255) begin
         $error("escs_bus_cycle: strobe widths out of range");
      end
   end

   typedef struct packed {
      logic        act;
      logic        wr;
      logic [7:0]  cnt;
      logic        done;
      logic [15:0] rdata;
      logic [15:0] dq_s1;
      logic [15:0] dq_s2;
      escs_pins_t  pins;
   } escs_bc_t;

   escs_bc_t st_ff;
   escs_bc_t nxt_st;

   always_comb begin
      nxt_st       = st_ff;
      nxt_st.done  = 1'b0;
      nxt_st.dq_s1 = dq_in;
      nxt_st.dq_s2 = st_ff.dq_s1;
      if (!st_ff.act) begin
         if (go) begin
            nxt_st.act          = 1'b1;
            nxt_st.wr           = is_write;
            nxt_st.cnt          = 8'h00;
            nxt_st.pins.addr    = addr;
            nxt_st.pins.dout    = wdata;
            nxt_st.pins.dout_en = is_write;
            nxt_st.pins.ce_n    = 1'b0;
            nxt_st.pins.we_n    = !is_write;
            nxt_st.pins.oe_n    = is_write;
         end
      end else begin
         nxt_st.cnt = st_ff.cnt + 8'h01;
         // Device latches data on the rising write strobe
         if (st_ff.cnt == 8'((st_ff.wr ? T_WR : T_RD) - 1)) begin
            nxt_st.pins.we_n = 1'b1;
            nxt_st.pins.oe_n = 1'b1;
            nxt_st.rdata     = st_ff.dq_s2;
         end
         if (st_ff.cnt == 8'(st_ff.wr ? T_WR : T_RD)) begin
            nxt_st.act          = 1'b0;
            nxt_st.done         = 1'b1;
            nxt_st.pins.ce_n    = 1'b1;
            nxt_st.pins.dout_en = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff      <= '0;
         st_ff.pins <= '{addr: 23'h00_0000, dout: 16'h0000, dout_en: 1'b0,
                        ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign busy  = st_ff.act;
   assign done  = st_ff.done;
   assign rdata = st_ff.rdata;
   assign pins  = st_ff.pins;
endmodule

//--- bench/escs_host_props.sv
`timescale 1ns/100ps
module escs_host_chk
   import escs_pkg::*;
#(
   parameter int unsigned ERS_SUSP_CYC = 800,
   parameter int unsigned PGM_SUSP_CYC = 600,
   parameter int unsigned T_WR         = 4,
   parameter int unsigned T_RD         = 4
) (
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire escs_req_t   req,
   input wire logic        rsp_valid,
   input wire escs_rsp_t   rsp,
   input wire logic [15:0] dq_in,
   input wire escs_pins_t  pins,
   input wire logic        flash_reset_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   reset_idle_a: assert property ($fell(srst) |-> pins.ce_n && pins.oe_n && pins.we_n
      && !pins.dout_en && !req_ready && !flash_reset_n) else $error("pins not idle after reset");
   wr_pulse_a: assert property ($fell(pins.we_n) |-> (!pins.we_n)[*4] ##1 pins.we_n)
      else $error("write strobe width wrong");
   wr_hold_a: assert property (!pins.we_n && $past(pins.we_n) == 1'b0 |->
      $stable(pins.addr) && $stable(pins.dout) && !pins.ce_n && pins.dout_en)
      else $error("write cycle not held");
   no_clash_a: assert property (!pins.oe_n |-> !pins.dout_en && pins.we_n)
      else $error("read overlaps a drive");
   cmd_data_a: assert property ($rose(pins.we_n) |-> pins.dout inside {16'h00AA,
      16'h0055, 16'h0080, 16'h0010, 16'h00B0, 16'h0030}) else $error("unknown command word");
   unlock_addr_a: assert property ($rose(pins.we_n) && pins.dout == 16'h0055 |->
      pins.addr == 23'h00_02AA) else $error("second unlock at wrong address");
   rsp_pulse_a: assert property (rsp_valid |-> rsp.done ##1 !rsp_valid)
      else $error("response not a one-cycle pulse");
   ready_idle_a: assert property (!pins.ce_n |-> !req_ready)
      else $error("ready during a bus cycle");
   ack_wait_a: assert property (req_valid && req_ready |-> ##[2:1000] rsp_valid)
      else $error("no response in time");
   cover property ($rose(pins.we_n) && pins.dout == 16'h0010);
   cover property ($rose(pins.we_n) && pins.dout == 16'h0030);
   cover property (rsp_valid && !rsp.timeout);
endmodule
bind escs_host escs_host_chk #(.ERS_SUSP_CYC(ERS_SUSP_CYC), .PGM_SUSP_CYC(PGM_SUSP_CYC),
   .T_WR(T_WR), .T_RD(T_RD)) i_chk (.clk(clk), .srst(srst), .req_valid(req_valid),
   .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .dq_in(dq_in),
   .pins(pins), .flash_reset_n(flash_reset_n));

//--- bench/escs_flash_model.sv
`timescale 1ns/100ps
module escs_flash_model
   import escs_pkg::*;
#(
   parameter int unsigned BUSY_RDS  = 6,
   parameter logic [22:0] SUSP_BASE = 23'h00_4000,
   parameter logic [15:0] ID_CODE   = 16'h5A5A // Arbitrary value
) (
   input  wire logic        clk,
   input  wire escs_pins_t  pins,
   input  wire logic        reset_n,
   input  wire logic [1:0]  kick,
   output      logic [15:0] dq
);
   localparam logic [2:0] IDL = 3'h0, CHP = 3'h1, SEC = 3'h2, ESU = 3'h3, PRG = 3'h4, PSU = 3'h5;
   logic [38:0] unl [6] = '{{23'h00_0555, 16'h00AA}, {23'h00_02AA, 16'h0055},
      {23'h00_0555, 16'h0080}, {23'h00_0555, 16'h00AA}, {23'h00_02AA, 16'h0055},
      {23'h00_0555, 16'h0010}};
   logic [2:0]  st_ff;
   logic [2:0]  seq_ff;
   logic        tog_ff;
   logic        nest_ff;
   logic        id_ff;
   logic        we_ff;
   logic        oe_ff;
   logic [15:0] held_ff = 16'h0000;
   logic [7:0]  rds_ff;
   int          n_wr_ff;
   logic [38:0] wlog_ff [64];
   logic [38:0] w;
   assign w = {pins.addr, pins.dout};
   always @(posedge clk) begin
      we_ff <= pins.we_n;
      oe_ff <= pins.oe_n;
      if (!reset_n) begin
         st_ff <= IDL;
         seq_ff <= 3'h0;
         n_wr_ff <= 0;
         tog_ff <= 1'b0;
         nest_ff <= 1'b0;
         id_ff <= 1'b0;
      end else begin
         if (kick == 2'h1)
            st_ff <= SEC;
         else if (kick == 2'h2) begin
            st_ff <= PRG;
            nest_ff <= (st_ff == ESU);
         end else if (kick == 2'h3)
            st_ff <= nest_ff ? ESU : IDL; // Program done
         // Latch on strobe rise; a busy chip erase drops every command except 00F0
         if (pins.we_n && !we_ff) begin
            wlog_ff[n_wr_ff[5:0]] <= w;
            n_wr_ff <= n_wr_ff + 1;
            seq_ff <= (w === unl[seq_ff]) ? seq_ff + 3'h1 : 3'h0;
            if (st_ff == IDL && seq_ff == 3'h5 && w === unl[5]) begin
               st_ff <= CHP;
               rds_ff <= 8'h00;
               seq_ff <= 3'h0;
            end else if (w[15:0] == 16'h00B0 && st_ff inside {SEC, PRG})
               st_ff <= (st_ff == SEC) ? ESU : PSU;
            else if (w[15:0] == 16'h0030 && st_ff inside {ESU, PSU})
               st_ff <= (st_ff == ESU) ? SEC : PRG;
            else if (w[15:0] == 16'h0090 && st_ff inside {ESU, PSU})
               id_ff <= 1'b1;
            else if (w[15:0] == 16'h00F0)
               id_ff <= 1'b0; // Back to the suspended state
         end
         if (!pins.oe_n && oe_ff) begin
            if (st_ff inside {CHP, SEC, PRG})
               tog_ff <= ~tog_ff;
            if (st_ff == CHP)
               rds_ff <= rds_ff + 8'h01;
            if (st_ff == CHP && rds_ff == BUSY_RDS - 1)
               st_ff <= IDL;
         end
      end
      if (!pins.oe_n && !pins.ce_n)
         held_ff <= dq;
   end
   always_comb begin
      if (pins.oe_n || pins.ce_n)
         dq = ~held_ff; // Released bus must not echo the last word
      else if (st_ff == IDL)
         dq = 16'hFFFF;
      else if (id_ff)
         dq = ID_CODE;
      else if (st_ff inside {ESU, PSU} && pins.addr[22:12] != SUSP_BASE[22:12])
         dq = 16'hFFFF; // Other sectors readable
      else
         dq = {8'h00, st_ff inside {ESU, PSU}, tog_ff, 3'h0, tog_ff, 2'h0};
   end
endmodule

//--- bench/testbench.sv
`timescale 1ns/100ps
module testbench;
   import escs_pkg::*;
   typedef struct packed {
      logic [1:0]  kick;
      escs_cmd_t   cmd;
      logic [15:0] data;
      logic [2:0]  st;
   } escs_row_t;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        req_valid = 1'b0;
   logic        req_ready;
   escs_req_t   req = '0;
   logic        rsp_valid;
   escs_rsp_t   rsp;
   escs_rsp_t   got = '0;
   logic [15:0] dq_in;
   escs_pins_t  pins;
   logic        flash_reset_n;
   logic [1:0]  kick = 2'h0;
   int          n_mismatch = 0;
   int          checks = 0;
   logic [38:0] unl [6] = '{{23'h00_0555, 16'h00AA}, {23'h00_02AA, 16'h0055},
      {23'h00_0555, 16'h0080}, {23'h00_0555, 16'h00AA}, {23'h00_02AA, 16'h0055},
      {23'h00_0555, 16'h0010}};
   escs_row_t   rows [9] = '{'{2'h1, ESCS_CMD_ERASE_SUSPEND, 16'h00B0, 3'h3},
      '{2'h0, ESCS_CMD_ERASE_RESUME, 16'h0030, 3'h2}, '{2'h0, ESCS_CMD_ERASE_RESUME, 16'h0030, 3'h2},
      '{2'h0, ESCS_CMD_ERASE_SUSPEND, 16'h00B0, 3'h3}, '{2'h2, ESCS_CMD_PGM_SUSPEND, 16'h00B0, 3'h5},
      '{2'h0, ESCS_CMD_PGM_RESUME, 16'h0030, 3'h4}, '{2'h0, ESCS_CMD_PGM_SUSPEND, 16'h00B0, 3'h5},
      '{2'h0, ESCS_CMD_PGM_RESUME, 16'h0030, 3'h4}, '{2'h3, ESCS_CMD_POLL, 16'h0030, 3'h3}};
   always #12.5 clk = ~clk;
   escs_host i_dut (.clk(clk), .srst(srst), .req_valid(req_valid), .req_ready(req_ready),
      .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .dq_in(dq_in), .pins(pins),
      .flash_reset_n(flash_reset_n));
   escs_flash_model i_flash (.clk(clk), .pins(pins), .reset_n(flash_reset_n), .kick(kick),
      .dq(dq_in));
   task automatic chk(input logic [38:0] seen, input logic [38:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic issue(input escs_cmd_t c, input bit wait_rsp,
                        input logic [22:0] a = 23'h00_4000);
      int n;
      n = 0;
      req <= '{c, a};
      req_valid <= 1'b1;
      @(posedge clk);
      while (req_ready !== 1'b1 && n < 4000) begin
         @(posedge clk);
         n++;
      end
      req_valid <= 1'b0;
      while (wait_rsp && rsp_valid !== 1'b1 && n < 4000) begin
         @(posedge clk);
         n++;
      end
      got = rsp;
      chk(n >= 4000, 0);
   endtask
   task automatic erase_all();
      int base;
      base = i_flash.n_wr_ff;
      issue(ESCS_CMD_CHIP_ERASE, 1'b1);
      for (int i = 0; i < 6; i++)
         chk(i_flash.wlog_ff[base + i], unl[i]);
      for (int i = 0; i < 20 && got.status !== 16'hFFFF; i++)
         issue(ESCS_CMD_POLL, 1'b1);
      chk(got.status, 16'hFFFF);
      chk(got.ok, 1'b1);
      chk(i_flash.st_ff, 3'h0);
      chk(i_flash.n_wr_ff - base, 6);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      erase_all();
      $display("test chip erase done");
      issue(ESCS_CMD_CHIP_ERASE, 1'b0);
      for (int i = 0; i < 200 && i_flash.st_ff !== 3'h1; i++)
         @(posedge clk);
      chk(i_flash.st_ff, 3'h1);
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      chk({flash_reset_n, rsp_valid, pins.we_n, pins.ce_n}, 4'b0011);
      chk(i_flash.st_ff, 3'h0);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      issue(ESCS_CMD_POLL, 1'b1);
      chk({got.ok, got.status}, 17'h1_FFFF);
      erase_all();
      $display("test reset abort done");
      foreach (rows[i]) begin
         kick <= rows[i].kick;
         @(posedge clk);
         kick <= 2'h0;
         issue(rows[i].cmd, 1'b1);
         chk(i_flash.wlog_ff[i_flash.n_wr_ff - 1][15:0], rows[i].data);
         chk(i_flash.st_ff, rows[i].st);
         chk(got.timeout, 1'b0);
         chk({got.done, got.ok}, 2'b11);
         if (rows[i].st inside {3'h3, 3'h5})
            chk(got.status[7], 1'b1);
      end
      $display("test suspend rows done");
      issue(ESCS_CMD_POLL, 1'b1, 23'h00_8000);
      chk(got.status, 16'hFFFF);
      issue(ESCS_CMD_POLL, 1'b1);
      chk(got.status[7], 1'b1);
      chk(got.ok, 1'b1);
      $display("test sector reads done");
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      tally_and_finish();
   end
endmodule
